// ==== hdl/fixed_io_decoder.sv ====
/*
  Router for upstream fixed legacy I/O cycles: picks internal unit,
  external enhanced SPI or PCIe, completes reserved and unclaimed cycles.
  Assumes one request per cycle, held only for the valid cycle; answers
  appear one clock later. Enable bits are static configuration inputs.
*/
`timescale 1ns/100ps
module fixed_io_decoder (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [15:0] req_addr,
   input wire logic [3:0] req_be,
   input wire logic [31:0] req_wdata,
   input wire logic postcode_route_select,
   input wire logic nmi_port_alias_enable,
   input wire logic rtc_upper_bank_enable,
   input wire logic superio_primary_fwd_enable,
   input wire logic superio_secondary_fwd_enable,
   input wire logic keyboard_fwd_enable,
   input wire logic microcontroller_fwd_enable,
   input wire logic gameport_low_fwd_enable,
   input wire logic gameport_high_fwd_enable,
   input wire logic spi_disable_strap,
   input wire logic reserved_hit,
   output logic fwd_valid,
   output logic [9:0] fwd_target,
   output logic fwd_write,
   output logic [15:0] fwd_addr,
   output logic [3:0] fwd_be,
   output logic [31:0] fwd_wdata,
   output logic cpl_valid,
   output logic [31:0] cpl_rdata
);
   // Strap after synchronisation
   logic spi_dis_sync;
   // Combinational decode result
   logic [9:0] tgt_next;
   // Address after alias folding
   logic [15:0] addr_next;
   // External enhanced SPI allowed at all
   logic spi_ok;

   io_sync2 strap_sync (
      .core_clk(core_clk),
      .rstn(rstn),
      .pin_in(spi_disable_strap),
      .pin_sync(spi_dis_sync)
   );

   assign spi_ok = ~spi_dis_sync;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // fixed ranges only, no overlap check; reserved_hit comes from the
   // variable-range side and fixed decode wins over it
   always_comb begin
      tgt_next = '0;
      addr_next = req_addr;
      if (req_addr[15:8] == 8'h00) begin
         unique casez (req_addr[7:0])
            // interrupt controller pairs
            // Patterns kept disjoint so the unique check never sees two hits
            8'b001?_??0?, 8'b1010_??0?, 8'b1011_?00?, 8'b1011_?10?: begin
               tgt_next[fixed_io_pkg::T_PIC] = 1'b1;
            end
            8'h2e, 8'h2f: begin
               tgt_next[fixed_io_pkg::T_SPI] = superio_primary_fwd_enable & spi_ok;
            end
            8'h40, 8'h42, 8'h43, 8'h50, 8'h52, 8'h53: begin
               tgt_next[fixed_io_pkg::T_TMR] = 1'b1;
            end
            8'h4e, 8'h4f: begin
               tgt_next[fixed_io_pkg::T_SPI] = superio_secondary_fwd_enable & spi_ok;
            end
            8'h60, 8'h64: begin
               tgt_next[fixed_io_pkg::T_SPI] = keyboard_fwd_enable & spi_ok;
            end
            8'h62, 8'h66: begin
               tgt_next[fixed_io_pkg::T_SPI] = microcontroller_fwd_enable & spi_ok;
            end
            8'h61: begin
               tgt_next[fixed_io_pkg::T_NMI] = 1'b1;
            end
            8'h63, 8'h65, 8'h67: begin
               tgt_next[fixed_io_pkg::T_NMI] = nmi_port_alias_enable;
               addr_next = fixed_io_pkg::A_NMI;
            end
            8'h70: begin
               tgt_next[fixed_io_pkg::T_RTC] = 1'b1;
               tgt_next[fixed_io_pkg::T_NMI] = req_write;
            end
            8'h71, 8'h74, 8'h75: begin
               tgt_next[fixed_io_pkg::T_RTC] = 1'b1;
            end
            8'h72, 8'h73, 8'h76, 8'h77: begin
               tgt_next[fixed_io_pkg::T_RTC] = 1'b1;
               if (!rtc_upper_bank_enable) begin
                  addr_next = {req_addr[15:2], 2'b00} & 16'hfff1;
                  addr_next[0] = req_addr[0];
               end
            end
            // postcode group, any size starting at 80h
            8'h80, 8'h84, 8'h85, 8'h86, 8'h88, 8'h8c, 8'h8d, 8'h8e: begin
               tgt_next[fixed_io_pkg::T_PCIE] = postcode_route_select;
               tgt_next[fixed_io_pkg::T_SPI] = ~postcode_route_select & spi_ok;
            end
            8'h90, 8'h94, 8'h95, 8'h96, 8'h98, 8'h9c, 8'h9d, 8'h9e: begin
               tgt_next[fixed_io_pkg::T_SPI] = spi_ok;
               addr_next = req_addr & 16'hffef;
            end
            8'h92: begin
               tgt_next[fixed_io_pkg::T_RST] = 1'b1;
            end
            8'hb2, 8'hb3: begin
               tgt_next[fixed_io_pkg::T_PM] = 1'b1;
            end
            default: begin
            end
         endcase
      end else if (req_addr[15:3] == fixed_io_pkg::A_GAME[15:3]) begin
         tgt_next[fixed_io_pkg::T_SPI] = gameport_low_fwd_enable & spi_ok;
      end else if (req_addr[15:3] == fixed_io_pkg::A_GAME[15:3] + 13'h0001) begin
         tgt_next[fixed_io_pkg::T_SPI] = gameport_high_fwd_enable & spi_ok;
      end else if (req_addr[15:1] == fixed_io_pkg::A_PIC_ELCR[15:1]) begin
         tgt_next[fixed_io_pkg::T_PIC] = 1'b1;
      end else if (req_addr == fixed_io_pkg::A_RSTCF9) begin
         tgt_next[fixed_io_pkg::T_RST] = 1'b1;
      end
      if (tgt_next == '0 && reserved_hit) begin
         tgt_next[fixed_io_pkg::T_RSV] = 1'b1;
      end
      if (tgt_next == '0) begin
         tgt_next[fixed_io_pkg::T_TERM] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Forward path to sideband and external ports
   // ----------------------------------------------------------------
   // relay claimed cycles
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fwd_valid <= 1'b0;
         fwd_target <= '0;
         fwd_write <= 1'b0;
         fwd_addr <= fixed_io_pkg::ADDR_RST;
         fwd_be <= 4'h0;
         fwd_wdata <= fixed_io_pkg::DATA_RST;
      end else begin
         fwd_valid <= req_valid & ~tgt_next[fixed_io_pkg::T_RSV]
                      & ~tgt_next[fixed_io_pkg::T_TERM];
         fwd_target <= req_valid ? tgt_next : '0;
         fwd_write <= req_write;
         fwd_addr <= addr_next;
         fwd_be <= req_be;
         fwd_wdata <= req_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Local completion of reserved and unclaimed cycles
   // ----------------------------------------------------------------
   // all ones on reads; writes dropped
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cpl_valid <= 1'b0;
         cpl_rdata <= fixed_io_pkg::DATA_RST;
      end else begin
         cpl_valid <= req_valid & (tgt_next[fixed_io_pkg::T_RSV]
                      | tgt_next[fixed_io_pkg::T_TERM]);
         cpl_rdata <= (req_valid & ~req_write & (tgt_next[fixed_io_pkg::T_RSV]
                      | tgt_next[fixed_io_pkg::T_TERM])) ? fixed_io_pkg::ALL_ONES
                      : fixed_io_pkg::DATA_RST;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   rsv_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (req_valid && !req_write && tgt_next[fixed_io_pkg::T_RSV])
      |=> (cpl_valid && cpl_rdata == fixed_io_pkg::ALL_ONES && !fwd_valid))
      else $error("reserved read not all ones");
   term_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (req_valid && tgt_next[fixed_io_pkg::T_TERM]) |=> (cpl_valid && !fwd_valid))
      else $error("unclaimed cycle not terminated");
   nmi_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (req_valid && req_addr == fixed_io_pkg::A_RTC_IDX)
      |=> (fwd_target[fixed_io_pkg::T_RTC] && fwd_target[fixed_io_pkg::T_NMI] == $past(req_write)))
      else $error("index port split wrong");
   post_route_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (req_valid && req_addr == 16'h0080 && postcode_route_select)
      |=> (fwd_valid && fwd_target[fixed_io_pkg::T_PCIE]))
      else $error("postcode not to PCIe");
   alias61_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (req_valid && req_addr == 16'h0063 && !nmi_port_alias_enable) |=> cpl_valid)
      else $error("alias not terminated");
   strap_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
      spi_dis_sync |=> !fwd_target[fixed_io_pkg::T_SPI])
      else $error("SPI forwarded while disabled");
   rtc_alias_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (req_valid && req_addr == 16'h0077 && !rtc_upper_bank_enable)
      |=> (fwd_addr == 16'h0071))
      else $error("RTC upper alias wrong");
   game_fwd_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (req_valid && req_addr == 16'h0203 && !gameport_low_fwd_enable) |=> cpl_valid)
      else $error("gameport forwarded while off");
endmodule

// ==== hdl/fixed_io_pkg.sv ====
/*
  Constants for the fixed legacy I/O decoder: address ranges, target
  codes and the reset values of its registers.
  Assumes a single 20 MHz core clock and an active-low asynchronous reset.
*/
package fixed_io_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;

   // ----------------------------------------------------------------
   // Target encoding (one bit per target in tgt vector; a 70h write sets both RTC and NMI)
   // ----------------------------------------------------------------
   localparam int TGT_W = 10;
   localparam int T_PIC = 0;   // Interrupt controller
   localparam int T_TMR = 1;   // Timer
   localparam int T_NMI = 2;   // NMI control
   localparam int T_RTC = 3;   // Real-time clock
   localparam int T_RST = 4;   // Reset generator
   localparam int T_PM = 5;    // Power management
   localparam int T_SPI = 6;   // External enhanced SPI
   localparam int T_PCIE = 7;  // External PCIe
   localparam int T_RSV = 8;   // Reserved: handled locally
   localparam int T_TERM = 9;  // Not decoded: terminated

   // ----------------------------------------------------------------
   // Fixed addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] A_NMI = 16'h0061;
   localparam logic [15:0] A_RTC_IDX = 16'h0070;
   localparam logic [15:0] A_RST92 = 16'h0092;
   localparam logic [15:0] A_RSTCF9 = 16'h0cf9;
   localparam logic [15:0] A_PIC_ELCR = 16'h04d0;
   localparam logic [15:0] A_GAME = 16'h0200;

   // ----------------------------------------------------------------
   // Reset values and all-ones read data
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] ALL_ONES = 32'hffffffff;
   localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
   localparam logic [15:0] ADDR_RST = 16'h0000;

endpackage

// ==== hdl/io_sync2.sv ====
/*
  Two-flop synchroniser for a strap pin that arrives from outside the
  core clock domain. Assumes the pin is quasi-static.
*/
`timescale 1ns/100ps
module io_sync2 (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic pin_in,
   output logic pin_sync
);
   // First stage, read only by the second
   logic meta_reg;

   // ----------------------------------------------------------------
   // Synchroniser chain
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         meta_reg <= pin_in;
         pin_sync <= meta_reg;
      end
   end
endmodule

// ==== verification/io_cycle_source.sv ====
/*
  Processor-side model that issues upstream I/O cycles to the decoder.
  Assumes the bench calls its tasks at the falling edge of core_clk.
*/
`timescale 1ns/100ps
module io_cycle_source (
   input wire logic core_clk,
   output logic req_valid,
   output logic req_write,
   output logic [15:0] req_addr,
   output logic [3:0] req_be,
   output logic [31:0] req_wdata
);
   // ----------------------------------------
   // Request driving
   // ----------------------------------------
   initial begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 16'h0;
      req_be = 4'h0;
      req_wdata = 32'h0;
   end
   // One request; stays up so back-to-back cycles need no gap
   task automatic cycle(input logic w, input logic [15:0] a, input logic [3:0] be,
                        input logic [31:0] d);
      req_valid = 1'b1;
      req_write = w;
      req_addr = a;
      req_be = be;
      req_wdata = d;
   endtask
   // Released lines show inverted data so a stale copy cannot pass
   task automatic idle(input int n);
      req_valid = 1'b0;
      req_addr = ~req_addr;
      req_wdata = ~req_wdata;
      req_be = ~req_be;
      repeat (n) @(negedge core_clk);
   endtask
endmodule

// ==== verification/fixed_io_decoder_tb.sv ====
/*
  Self-checking bench for the fixed I/O decoder.
  Assumes one-cycle answers and a two-edge strap synchroniser.
*/
`timescale 1ns/100ps
module fixed_io_decoder_tb;
   // ----------------------------------------
   // Signals and expected target masks
   // ----------------------------------------
   localparam logic [9:0] PIC = 10'h001, TMR = 10'h002, NMI = 10'h004, RTC = 10'h008;
   localparam logic [9:0] RST = 10'h010, PM = 10'h020, SPI = 10'h040, PCI = 10'h080;
   localparam logic [9:0] RSV = 10'h100, TRM = 10'h200;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [10:0] cfg = 11'h0; // Static configuration bits and reserved flag
   logic req_valid, req_write, fwd_valid, fwd_write, cpl_valid;
   logic [15:0] req_addr, fwd_addr;
   logic [3:0] req_be, fwd_be;
   logic [31:0] req_wdata, fwd_wdata, cpl_rdata;
   logic [9:0] fwd_target;
   int mismatches = 0;
   int checks_done = 0;
   io_cycle_source src (.core_clk(core_clk), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata));
   fixed_io_decoder uut (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata),
      .postcode_route_select(cfg[0]), .nmi_port_alias_enable(cfg[1]),
      .rtc_upper_bank_enable(cfg[2]), .superio_primary_fwd_enable(cfg[3]),
      .superio_secondary_fwd_enable(cfg[4]), .keyboard_fwd_enable(cfg[5]),
      .microcontroller_fwd_enable(cfg[6]), .gameport_low_fwd_enable(cfg[7]),
      .gameport_high_fwd_enable(cfg[8]), .spi_disable_strap(cfg[9]), .reserved_hit(cfg[10]),
      .fwd_valid(fwd_valid), .fwd_target(fwd_target), .fwd_write(fwd_write),
      .fwd_addr(fwd_addr), .fwd_be(fwd_be), .fwd_wdata(fwd_wdata), .cpl_valid(cpl_valid),
      .cpl_rdata(cpl_rdata));
   // ----------------------------------------
   // Clock, checks and closing
   // ----------------------------------------
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      if (mismatches == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // One cycle, answer sampled one clock later; locally completed reads give all ones
   task automatic t(input logic w, input logic [15:0] a, input logic [9:0] tg,
                    input logic [15:0] ea, input logic [3:0] be = 4'hf);
      logic fw;
      fw = !(tg[8] | tg[9]);
      src.cycle(w, a, be, {a, a});
      @(posedge core_clk);
      @(negedge core_clk);
      cmp({fwd_valid, cpl_valid, fwd_target}, {fw, !fw, tg});
      if (fw) begin
         cmp({fwd_write, fwd_be, fwd_addr}, {w, be, ea});
         if (w) cmp(fwd_wdata, {a, a});
      end else begin
         cmp(cpl_rdata, w ? 32'h0 : 32'hffffffff);
      end
   endtask
   // Watchdog: a hang counts as a mismatch
   initial begin
      repeat (5000) @(posedge core_clk);
      mismatches++;
      conclude();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(negedge core_clk);
      rstn = 1'b1;
      repeat (3) @(negedge core_clk);
      t(0, 16'h20, PIC, 16'h20);
      t(1, 16'h3d, PIC, 16'h3d);
      t(0, 16'hbd, PIC, 16'hbd);
      t(0, 16'h4d1, PIC, 16'h4d1);
      t(0, 16'h40, TMR, 16'h40);
      t(1, 16'h53, TMR, 16'h53);
      t(0, 16'hb2, PM, 16'hb2);
      t(1, 16'h92, RST, 16'h92);
      t(0, 16'hcf9, RST, 16'hcf9);
      t(0, 16'h22, TRM, 16'h0);
      t(1, 16'h41, TRM, 16'h0);
      t(0, 16'h300, TRM, 16'h0);
      t(1, 16'h70, NMI | RTC, 16'h70);
      t(0, 16'h70, RTC, 16'h70);
      t(0, 16'h61, NMI, 16'h61);
      t(0, 16'h63, TRM, 16'h0);
      t(0, 16'h72, RTC, 16'h70);
      t(1, 16'h77, RTC, 16'h71);
      t(0, 16'h80, SPI, 16'h80, 4'h1);
      t(1, 16'h80, SPI, 16'h80, 4'h3);
      t(0, 16'h8e, SPI, 16'h8e);
      t(0, 16'h90, SPI, 16'h80);
      t(1, 16'h9e, SPI, 16'h8e);
      t(0, 16'h2e, TRM, 16'h0);
      t(0, 16'h4f, TRM, 16'h0);
      t(1, 16'h60, TRM, 16'h0);
      t(0, 16'h66, TRM, 16'h0);
      t(0, 16'h200, TRM, 16'h0);
      t(0, 16'h203, TRM, 16'h0);
      t(0, 16'h20f, TRM, 16'h0);
      src.idle(1);
      cfg = 11'h1ff;
      t(0, 16'h63, NMI, 16'h61);
      t(1, 16'h65, NMI, 16'h61);
      t(0, 16'h67, NMI, 16'h61);
      t(0, 16'h72, RTC, 16'h72);
      t(1, 16'h77, RTC, 16'h77);
      t(0, 16'h80, PCI, 16'h80, 4'h1);
      t(1, 16'h80, PCI, 16'h80);
      t(0, 16'h84, PCI, 16'h84);
      t(1, 16'h88, PCI, 16'h88);
      t(0, 16'h94, SPI, 16'h84);
      t(0, 16'h98, SPI, 16'h88);
      t(1, 16'h2f, SPI, 16'h2f);
      t(0, 16'h4e, SPI, 16'h4e);
      t(0, 16'h64, SPI, 16'h64);
      t(1, 16'h62, SPI, 16'h62);
      t(0, 16'h207, SPI, 16'h207);
      t(1, 16'h208, SPI, 16'h208);
      src.idle(1);
      cfg = 11'h5ff;
      t(0, 16'h300, RSV, 16'h0);
      t(1, 16'h300, RSV, 16'h0);
      t(0, 16'h61, NMI, 16'h61);
      src.idle(1);
      cfg = 11'h3fe;
      src.idle(3);
      t(0, 16'h2e, TRM, 16'h0);
      t(0, 16'h80, TRM, 16'h0);
      t(1, 16'h20f, TRM, 16'h0);
      src.idle(2);
      conclude();
   end
endmodule
